// ===== hdl/ast_pkg.sv
// package: register map, field positions, reset values and state types of the serial transceiver
package ast_pkg;
   // register addresses
   localparam logic [15:0] ADDR_MODE = 16'hff70;
   localparam logic [15:0] ADDR_BAUD = 16'hff71;
   localparam logic [15:0] ADDR_DATA = 16'hff72;
   localparam logic [15:0] ADDR_ERR = 16'hff73;
   // reset values and baud write mask
   localparam logic [7:0] MODE_RESET = 8'h01;
   localparam logic [7:0] BAUD_RESET = 8'h1f;
   localparam logic [7:0] BAUD_MASK = 8'hdf;
   localparam logic [7:0] HOLD_RESET = 8'hff;
   localparam logic [7:0] TXS_RESET = 8'hff;
   localparam logic [2:0] ERR_RESET = 3'h0;
   localparam logic [1:0] SYNC_RESET = 2'h3;
   // line_mode_reg fields
   localparam int POWER_BIT = 7;
   localparam int TXE_BIT = 6;
   localparam int RXE_BIT = 5;
   localparam int PS_HI_BIT = 4;
   localparam int PS_LO_BIT = 3;
   localparam int CL_BIT = 2;
   localparam int SL_BIT = 1;
   // rx_error_reg fields
   localparam int PE_BIT = 2;
   localparam int FE_BIT = 1;
   localparam int OVE_BIT = 0;
   // baud_divider_reg fields
   localparam int SEL_HI_BIT = 7;
   localparam int SEL_LO_BIT = 6;
   localparam int K_MSB = 4;
   localparam logic [4:0] K_MIN = 5'h08;
   // base clock prescaler: last count of ref_clk/2, /8, /32
   localparam logic [1:0] SEL_EXT = 2'h0;
   localparam logic [1:0] SEL_DIV2 = 2'h1;
   localparam logic [1:0] SEL_DIV8 = 2'h2;
   localparam logic [4:0] PRE_LAST_2 = 5'h01;
   localparam logic [4:0] PRE_LAST_8 = 5'h07;
   localparam logic [4:0] PRE_LAST_32 = 5'h1f;
   // last data bit index for 7 and 8 bit characters
   localparam logic [2:0] LAST_BIT_7 = 3'h6;
   localparam logic [2:0] LAST_BIT_8 = 3'h7;

   typedef enum logic [1:0] {
      PAR_NONE = 2'h0,
      PAR_ZERO = 2'h1,
      PAR_ODD = 2'h2,
      PAR_EVEN = 2'h3
   } ast_par_t;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_START = 5'h02,
      TX_DATA = 5'h04,
      TX_PAR = 5'h08,
      TX_STOP = 5'h10
   } ast_tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_PAR = 5'h08,
      RX_STOP = 5'h10
   } ast_rx_state_t;

   typedef struct packed {
      logic meta;
      logic level;
   } ast_sync_state_t;

   typedef struct packed {
      logic [4:0] pre_cnt;
      logic ext_prev;
      logic tick;
   } ast_baud_state_t;

   typedef struct packed {
      logic [7:0] line_mode_reg;
      logic [7:0] baud_divider_reg;
      logic [7:0] tx_shifter_reg;
      logic [7:0] rx_holding_reg;
      logic [2:0] rx_error_reg;
      logic unread;
      logic [7:0] rd_data;
      logic tx_run;
      logic rx_run;
      ast_tx_state_t tx_st;
      logic [5:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic tx_more_stop;
      logic tx_out;
      logic tx_done_irq;
      ast_rx_state_t rx_st;
      logic [5:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_shifter;
      logic rx_par;
      logic rx_pe;
      logic rx_done_irq;
      logic err_irq;
   } ast_top_state_t;
endpackage : ast_pkg

// ===== hdl/ast_sync.sv
// two flip-flop synchroniser for a pin level
module ast_sync
   import ast_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // level
   input wire logic async_in,
   output logic sync_out
);
   ast_sync_state_t s;
   ast_sync_state_t next_s;

   always_comb begin
      next_s.meta = async_in;
      next_s.level = s.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s <= SYNC_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.level;
endmodule : ast_sync

// ===== hdl/ast_baud.sv
// base clock prescaler: one-cycle base tick enable, stopped while the unit is powered down
module ast_baud
   import ast_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // control
   input wire logic run,
   input wire logic [1:0] clk_sel,
   input wire logic ext_level,
   // tick
   output logic base_tick
);
   ast_baud_state_t s;
   ast_baud_state_t next_s;
   logic [4:0] pre_last;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      next_s.ext_prev = ext_level;
      pre_last = PRE_LAST_32;
      if (clk_sel == SEL_DIV2) begin
         pre_last = PRE_LAST_2;
      end else if (clk_sel == SEL_DIV8) begin
         pre_last = PRE_LAST_8;
      end
      // powered down: the base clock is held still
      if (!run) begin
         next_s.pre_cnt = '0;
      end else if (clk_sel == SEL_EXT) begin
         next_s.tick = ext_level & ~s.ext_prev;
      end else if (s.pre_cnt >= pre_last) begin
         next_s.pre_cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.pre_cnt = s.pre_cnt + 5'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign base_tick = s.tick;
endmodule : ast_baud

// ===== hdl/ast_top.sv
// asynchronous serial transceiver: registers, transmitter, receiver
// What this block does
// - power off resets unit, stops clock
// - powered off, serial input reads high
// - tx enable clear resets transmitter
// - rx enable clear resets receiver
// - zero parity never sets parity error
// - length bit picks 7 or 8 bits
// - stop bit picks one or two stops
// - receiver always expects one stop bit
// - low line at enable starts reception
// - enables sampled on base clock tick
// - transmit write starts frame, lsb first
// - received char copied, 7-bit msb zero
// - overrun keeps old holding contents
// - holding read-only, resets to all ones
// - tx shifter write-only, resets ones
// - error flags cleared by resets, rx off
// - parity and framing errors; read clears
// - overrun when new char ends, old unread
// - baud is base clock over 2k
//
// Local design decision: the plain strobed port.
module ast_top
   import ast_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port
   input wire logic [15:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // serial pins and external base clock source
   input wire logic serial_in_pin,
   input wire logic ext_timer_in,
   output logic serial_out_pin,
   // event pulses
   output logic tx_done_irq,
   output logic rx_done_irq,
   output logic err_irq
);
   ast_top_state_t s;
   ast_top_state_t next_s;
   logic rx_pin_sync;
   logic ext_sync;
   logic base_tick;
   logic power;
   logic rx_line;
   logic [4:0] k_val;
   logic [5:0] bit_last;
   logic [5:0] half_last;
   logic char8;
   ast_par_t psel;
   logic tx_start;
   logic tx_active;
   logic rx_active;
   logic rx_finish;
   logic rx_overrun;
   logic rx_store;
   logic rd_err;
   logic rd_hold;
   logic [7:0] rx_char;

   // clamps k into its legal range; settings below 8 would give a runaway baud
   function automatic logic [4:0] k_of(input logic [7:0] baud);
      k_of = (baud[K_MSB:0] < K_MIN) ? K_MIN : baud[K_MSB:0];
   endfunction : k_of

   // parity bit to send for a character, given length and parity code
   function automatic logic par_of(input logic [7:0] d, input logic c8, input ast_par_t p);
      logic ones;
      ones = c8 ? ^d : ^d[LAST_BIT_7:0];
      unique case (p)
         PAR_ODD: par_of = ~ones;
         PAR_EVEN: par_of = ones;
         default: par_of = 1'b0;
      endcase
   endfunction : par_of

   ast_sync u_rx_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in(serial_in_pin),
      .sync_out(rx_pin_sync)
   );

   ast_sync u_ext_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in(ext_timer_in),
      .sync_out(ext_sync)
   );

   // base clock only runs while powered
   ast_baud u_baud (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .run(power),
      .clk_sel(s.baud_divider_reg[SEL_HI_BIT:SEL_LO_BIT]),
      .ext_level(ext_sync),
      .base_tick(base_tick)
   );

   assign power = s.line_mode_reg[POWER_BIT];
   assign rx_line = power ? rx_pin_sync : 1'b1;
   assign k_val = k_of(s.baud_divider_reg);
   assign bit_last = {k_val - 5'h01, 1'b1};
   assign half_last = {1'b0, k_val - 5'h01};
   assign char8 = s.line_mode_reg[CL_BIT];
   assign psel = ast_par_t'(s.line_mode_reg[PS_HI_BIT:PS_LO_BIT]);
   assign tx_active = s.tx_run && power;
   assign rx_active = s.rx_run && power;
   assign tx_start = wr_en && addr == ADDR_DATA && tx_active && s.tx_st == TX_IDLE;
   assign rd_err = rd_en && addr == ADDR_ERR;
   assign rd_hold = rd_en && addr == ADDR_DATA;
   assign rx_finish = rx_active && base_tick && s.rx_st == RX_STOP && s.rx_cnt == bit_last;
   // a read in the same cycle frees the holding register, so no overrun then
   assign rx_overrun = rx_finish && s.unread && !rd_hold;
   assign rx_store = rx_finish && !rx_overrun;
   assign rx_char = char8 ? s.rx_shifter : {1'b0, s.rx_shifter[7:1]};

   always_comb begin
      next_s = s;
      next_s.rd_data = '0;
      next_s.tx_done_irq = 1'b0;
      next_s.rx_done_irq = 1'b0;
      next_s.err_irq = 1'b0;
      // register writes and reads
      if (wr_en && addr == ADDR_MODE) begin
         next_s.line_mode_reg = wr_data;
      end
      if (wr_en && addr == ADDR_BAUD) begin
         next_s.baud_divider_reg = wr_data & BAUD_MASK;
      end
      if (rd_en) begin
         unique case (addr)
            ADDR_MODE: next_s.rd_data = s.line_mode_reg;
            ADDR_BAUD: next_s.rd_data = s.baud_divider_reg;
            ADDR_DATA: next_s.rd_data = s.rx_holding_reg;
            ADDR_ERR: next_s.rd_data = {5'h00, s.rx_error_reg};
            default: next_s.rd_data = '0;
         endcase
      end
      // clears first, so an error raised in this same cycle survives
      if (rd_err) begin
         next_s.rx_error_reg = ERR_RESET;
      end
      if (rd_hold) begin
         next_s.unread = 1'b0;
      end
      // enables take effect on a base clock tick only
      if (base_tick) begin
         next_s.tx_run = power && s.line_mode_reg[TXE_BIT];
         next_s.rx_run = power && s.line_mode_reg[RXE_BIT];
      end

      // transmitter
      if (!tx_active) begin
         next_s.tx_st = TX_IDLE;
         next_s.tx_out = 1'b1;
         next_s.tx_cnt = '0;
         next_s.tx_shifter_reg = TXS_RESET;
      end else if (tx_start) begin
         next_s.tx_shifter_reg = wr_data;
         next_s.tx_sh = wr_data;
         next_s.tx_par = par_of(wr_data, char8, psel);
         next_s.tx_st = TX_START;
         next_s.tx_out = 1'b0;
         next_s.tx_cnt = '0;
      end else if (base_tick && s.tx_st != TX_IDLE) begin
         if (s.tx_cnt != bit_last) begin
            next_s.tx_cnt = s.tx_cnt + 6'h01;
         end else begin
            next_s.tx_cnt = '0;
            unique case (s.tx_st)
               TX_START: begin
                  next_s.tx_st = TX_DATA;
                  next_s.tx_bit = '0;
                  next_s.tx_out = s.tx_sh[0];
                  next_s.tx_sh = s.tx_sh >> 1;
               end
               TX_DATA: begin
                  if (s.tx_bit == (char8 ? LAST_BIT_8 : LAST_BIT_7)) begin
                     if (psel != PAR_NONE) begin
                        next_s.tx_st = TX_PAR;
                        next_s.tx_out = s.tx_par;
                     end else begin
                        next_s.tx_st = TX_STOP;
                        next_s.tx_out = 1'b1;
                        next_s.tx_more_stop = s.line_mode_reg[SL_BIT];
                     end
                  end else begin
                     next_s.tx_bit = s.tx_bit + 3'h1;
                     next_s.tx_out = s.tx_sh[0];
                     next_s.tx_sh = s.tx_sh >> 1;
                  end
               end
               TX_PAR: begin
                  next_s.tx_st = TX_STOP;
                  next_s.tx_out = 1'b1;
                  next_s.tx_more_stop = s.line_mode_reg[SL_BIT];
               end
               TX_STOP: begin
                  if (s.tx_more_stop) begin
                     next_s.tx_more_stop = 1'b0;
                  end else begin
                     next_s.tx_st = TX_IDLE;
                     next_s.tx_done_irq = 1'b1;
                  end
               end
               default: begin
                  next_s.tx_st = TX_IDLE;
                  next_s.tx_out = 1'b1;
               end
            endcase
         end
      end

      // receiver
      if (!rx_active) begin
         next_s.rx_st = RX_IDLE;
         next_s.rx_cnt = '0;
         next_s.rx_error_reg = ERR_RESET;
      end else if (base_tick) begin
         if (s.rx_st == RX_IDLE) begin
            // no idle-high check: a line already low starts a character
            if (!rx_line) begin
               next_s.rx_st = RX_START;
               next_s.rx_cnt = '0;
            end
         end else if (s.rx_st == RX_START && s.rx_cnt != half_last) begin
            next_s.rx_cnt = s.rx_cnt + 6'h01;
         end else if (s.rx_st != RX_START && s.rx_cnt != bit_last) begin
            next_s.rx_cnt = s.rx_cnt + 6'h01;
         end else begin
            next_s.rx_cnt = '0;
            unique case (s.rx_st)
               RX_START: begin
                  // start bit sampled mid-bit; a glitch returns to idle
                  next_s.rx_st = rx_line ? RX_IDLE : RX_DATA;
                  next_s.rx_bit = '0;
                  next_s.rx_par = 1'b0;
               end
               RX_DATA: begin
                  next_s.rx_shifter = {rx_line, s.rx_shifter[7:1]};
                  next_s.rx_par = s.rx_par ^ rx_line;
                  next_s.rx_pe = 1'b0;
                  if (s.rx_bit == (char8 ? LAST_BIT_8 : LAST_BIT_7)) begin
                     next_s.rx_st = (psel != PAR_NONE) ? RX_PAR : RX_STOP;
                  end else begin
                     next_s.rx_bit = s.rx_bit + 3'h1;
                  end
               end
               RX_PAR: begin
                  next_s.rx_st = RX_STOP;
                  next_s.rx_pe = (psel == PAR_ODD && !(s.rx_par ^ rx_line)) ||
                     (psel == PAR_EVEN && (s.rx_par ^ rx_line));
               end
               RX_STOP: begin
                  // only the first stop bit is looked at
                  next_s.rx_st = RX_IDLE;
                  if (s.rx_pe) begin
                     next_s.rx_error_reg[PE_BIT] = 1'b1;
                  end
                  if (!rx_line) begin
                     next_s.rx_error_reg[FE_BIT] = 1'b1;
                  end
                  if (rx_overrun) begin
                     next_s.rx_error_reg[OVE_BIT] = 1'b1;
                  end else begin
                     next_s.rx_holding_reg = rx_char;
                     next_s.unread = 1'b1;
                     next_s.rx_done_irq = 1'b1;
                  end
                  next_s.err_irq = s.rx_pe || !rx_line || rx_overrun;
               end
               default: next_s.rx_st = RX_IDLE;
            endcase
         end
      end

      // unit powered down: enables, tx shifter, holding, error and unread flags reset
      if (!power) begin
         next_s.tx_run = 1'b0;
         next_s.rx_run = 1'b0;
         next_s.tx_shifter_reg = TXS_RESET;
         next_s.rx_holding_reg = HOLD_RESET;
         next_s.rx_error_reg = ERR_RESET;
         next_s.unread = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s <= '0;
         s.line_mode_reg <= MODE_RESET;
         s.baud_divider_reg <= BAUD_RESET;
         s.tx_shifter_reg <= TXS_RESET;
         s.rx_holding_reg <= HOLD_RESET;
         s.rx_error_reg <= ERR_RESET;
         s.tx_st <= TX_IDLE;
         s.rx_st <= RX_IDLE;
         s.tx_out <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data = s.rd_data;
   assign serial_out_pin = s.tx_out;
   assign tx_done_irq = s.tx_done_irq;
   assign rx_done_irq = s.rx_done_irq;
   assign err_irq = s.err_irq;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_power_off_reset: assert property (
      !power |=> serial_out_pin && s.rx_holding_reg == HOLD_RESET && s.rx_error_reg == ERR_RESET &&
         s.tx_st == TX_IDLE)
      else $error("power off did not reset the unit");
   chk_rx_line_forced: assert property (!power |-> rx_line)
      else $error("serial input not held high while powered down");
   chk_tx_disable_reset: assert property (
      !tx_active |=> s.tx_st == TX_IDLE && s.tx_shifter_reg == TXS_RESET && serial_out_pin)
      else $error("transmitter not reset while disabled");
   chk_rx_disable_reset: assert property (
      !rx_active |=> s.rx_st == RX_IDLE && s.rx_error_reg == ERR_RESET)
      else $error("receiver not reset while disabled");
   chk_zero_parity_quiet: assert property (
      $rose(s.rx_error_reg[PE_BIT]) |-> $past(psel) inside {PAR_ODD, PAR_EVEN})
      else $error("parity error raised without a checked parity mode");
   chk_tx_start_low: assert property (
      tx_start |=> !serial_out_pin && s.tx_st == TX_START ##1 !serial_out_pin)
      else $error("transmit write did not drive a start bit");
   chk_stop_bits_high: assert property ((s.tx_st == TX_STOP) |-> serial_out_pin)
      else $error("stop bit not high");
   chk_hold_seven_bit: assert property (
      rx_store && !char8 |=> !s.rx_holding_reg[7] && s.rx_done_irq && s.unread)
      else $error("seven bit character not stored with clear top bit");
   chk_overrun_keeps: assert property (
      rx_overrun |=> s.rx_holding_reg == $past(s.rx_holding_reg) && s.rx_error_reg[OVE_BIT] &&
         !s.rx_done_irq)
      else $error("overrun overwrote holding register or lost the flag");
   chk_status_read_clear: assert property (
      rd_err && !rx_finish |=> s.rx_error_reg == ERR_RESET)
      else $error("status read did not clear the error flags");

   cov_tx_done: cover property (tx_start ##[1:1000] s.tx_done_irq);
   cov_rx_done: cover property (s.rx_done_irq);
   cov_overrun: cover property (rx_overrun);
   cov_framing: cover property ($rose(s.rx_error_reg[FE_BIT]));
endmodule : ast_top

// ===== verification/ast_peer.sv
// remote serial partner: frame sender and mid-bit sampler on the two pins
module ast_peer #(
   parameter int BIT_CYC = 32
) (
   // clock
   input wire logic ref_clk,
   // serial pins
   input wire logic serial_out_pin,
   output logic serial_in_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] cap;
   initial begin
      serial_in_pin = 1'b1;
      cap = 12'hfff;
   end
   // lsb-first bit list, one bit per bit time, then back to idle high
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         serial_in_pin <= bits[i];
         repeat (BIT_CYC) @(posedge ref_clk);
      end
      serial_in_pin <= 1'b1;
   endtask : send
   // no glitch filter: a short start pulse shows up as a bad frame, not as silence
   always begin
      @(negedge serial_out_pin);
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      for (int i = 0; i < 12; i++) begin
         cap[i] = serial_out_pin;
         repeat (BIT_CYC) @(posedge ref_clk);
      end
   end
endmodule : ast_peer

// ===== verification/ast_top_bench.sv
// self-checking bench for the serial transceiver with a remote partner
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module ast_top_bench
   import ast_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic ext_timer_in = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_data;
   logic serial_in_pin, serial_out_pin, tx_done_irq, rx_done_irq, err_irq;
   int bad_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;
   logic [11:0] f;
   logic [7:0] d = 8'h5a;
   logic [7:0] d2;
   logic [7:0] mode_now = 8'h01;

   always #4 ref_clk = ~ref_clk;
   // whole run needs under 20000 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      ext_timer_in <= cyc[2];
      if (cyc == 40000) begin
         bad_count++;
         summarize();
      end
   end

   ast_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .serial_in_pin(serial_in_pin),
      .ext_timer_in(ext_timer_in), .serial_out_pin(serial_out_pin),
      .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .err_irq(err_irq));
   ast_peer #(.BIT_CYC(32)) peer (.ref_clk(ref_clk), .serial_out_pin(serial_out_pin),
      .serial_in_pin(serial_in_pin));

   function automatic logic [11:0] frame(input logic [7:0] v, input logic [1:0] ps,
                                         input logic cl);
      logic [11:0] r;
      logic p;
      r = 12'hffe;
      for (int i = 0; i < (cl ? 8 : 7); i++) r[i + 1] = v[i];
      p = cl ? ^v : ^v[6:0];
      if (ps != 2'h0) r[cl ? 9 : 8] = (ps == 2'h1) ? 1'b0 : (ps == 2'h2) ? ~p : p;
      return r;
   endfunction : frame

   function automatic int flen(input logic [1:0] ps, input logic cl, input logic sl);
      return (cl ? 10 : 9) + (ps != 2'h0 ? 1 : 0) + (sl ? 1 : 0);
   endfunction : flen

   function automatic logic hit(input int w);
      return w == 0 ? tx_done_irq === 1'b1 : w == 1 ? rx_done_irq === 1'b1 : err_irq === 1'b1;
   endfunction : hit

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic chkrd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(negedge ref_clk);
      `CHK(rd_data, e)
      // read data stands one cycle only, then drops back to zero
      @(negedge ref_clk);
      `CHK(rd_data, 8'h00)
   endtask : chkrd

   task automatic await(input int w, output int k);
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (k < 2000 && !hit(w));
   endtask : await

   task automatic xsend(input logic [11:0] b, input int w);
      fork
         peer.send(b, 12);
         await(w, n);
      join
      `CHK(n < 2000, 1'b1)
   endtask : xsend

   // enables dropped first with old fields kept, fields changed only once they are off
   task automatic cfg(input logic [1:0] ps, input logic cl, input logic sl);
      wr(ADDR_MODE, {3'b100, mode_now[4:0]});
      repeat (8) @(posedge ref_clk);
      wr(ADDR_MODE, {3'b100, ps, cl, sl, 1'b1});
      mode_now = {3'b111, ps, cl, sl, 1'b1};
      wr(ADDR_MODE, mode_now);
      repeat (8) @(posedge ref_clk);
   endtask : cfg

   task automatic summarize();
      $display("bad_count %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   initial begin
      void'($urandom(32'hb41199dd));
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      chkrd(ADDR_MODE, MODE_RESET);
      chkrd(ADDR_BAUD, BAUD_RESET);
      chkrd(ADDR_DATA, HOLD_RESET);
      chkrd(ADDR_ERR, 8'h00);
      chkrd(16'h0000, 8'h00);
      wr(ADDR_ERR, 8'h07);
      chkrd(ADDR_ERR, 8'h00);
      wr(ADDR_BAUD, {SEL_DIV2, 6'h08});
      wr(ADDR_MODE, 8'h81);
      for (int c = 0; c < 16; c++) begin
         cfg(c[1:0], c[2], c[3]);
         d2 = (c == 0) ? 8'h80 : 8'($urandom);
         wr(ADDR_DATA, d2);
         await(0, n);
         `CHK(n >= flen(c[1:0], c[2], c[3]) * 32 - 4 && n <= flen(c[1:0], c[2], c[3]) * 32 + 4, 1'b1)
         repeat (40) @(posedge ref_clk);
         `CHK(peer.cap, frame(d2, c[1:0], c[2]))
         d2 = 8'($urandom);
         xsend(frame(d2, c[1:0], c[2]), 1);
         chkrd(ADDR_DATA, c[2] ? d2 : {1'b0, d2[6:0]});
         chkrd(ADDR_ERR, 8'h00);
      end
      cfg(PAR_ODD, 1'b1, 1'b0);
      f = frame(d, PAR_ODD, 1'b1);
      f[9] = ~f[9];
      xsend(f, 2);
      chkrd(ADDR_ERR, 8'h04);
      chkrd(ADDR_ERR, 8'h00);
      chkrd(ADDR_DATA, d);
      d2 = 8'($urandom);
      xsend(frame(d2, PAR_ODD, 1'b1), 1);
      xsend(frame(~d2, PAR_ODD, 1'b1), 2);
      chkrd(ADDR_DATA, d2);
      chkrd(ADDR_ERR, 8'h01);
      cfg(PAR_ZERO, 1'b1, 1'b0);
      f = frame(d, PAR_ZERO, 1'b1);
      f[9] = 1'b1;
      xsend(f, 1);
      chkrd(ADDR_ERR, 8'h00);
      chkrd(ADDR_DATA, d);
      // low stop bit; the receiver is switched off at once so a trailing false start is dropped
      f = frame(d, PAR_ZERO, 1'b1);
      f[10] = 1'b0;
      xsend(f, 2);
      chkrd(ADDR_ERR, 8'h02);
      chkrd(ADDR_DATA, d);
      wr(ADDR_MODE, 8'hcd);
      repeat (8) @(posedge ref_clk);
      chkrd(ADDR_ERR, 8'h00);
      wr(ADDR_DATA, 8'h00);
      repeat (100) @(posedge ref_clk);
      wr(ADDR_MODE, 8'h8d);
      repeat (16) @(posedge ref_clk);
      `CHK(serial_out_pin, 1'b1)
      wr(ADDR_DATA, 8'h00);
      repeat (40) @(posedge ref_clk);
      `CHK(serial_out_pin, 1'b1)
      // external base clock: one tick per timer rising edge, every 8 cycles, so 128 per bit
      wr(ADDR_BAUD, {SEL_EXT, 6'h08});
      chkrd(ADDR_BAUD, {SEL_EXT, 6'h08});
      wr(ADDR_MODE, 8'hcd);
      repeat (40) @(posedge ref_clk);
      wr(ADDR_DATA, 8'h3c);
      await(0, n);
      `CHK(n >= 11 * 128 - 12 && n <= 11 * 128 + 12, 1'b1)
      wr(ADDR_MODE, 8'h8d);
      repeat (40) @(posedge ref_clk);
      wr(ADDR_MODE, 8'h01);
      repeat (4) @(posedge ref_clk);
      chkrd(ADDR_DATA, HOLD_RESET);
      chkrd(ADDR_MODE, 8'h01);
      summarize();
   end
endmodule : ast_top_bench
